// [mpl_ctrl_model.sv]
// External programming controller driving the supply line.
// Assumes the caller waits for any reply before the next frame.
`timescale 1ns/1ps
`default_nettype none
module mpl_ctrl_model
(
  // Clock
  input wire logic clk,
  // Supply line, idles high
  output logic line
);
  initial line = 1'b1;

  // Sends two syncs, then the low n bits MSB first
  task automatic send(input logic [41:0] bits, input int n, input int t);
    logic b;
    for (int i = n + 1; i >= 0; i--)
    begin
      b = (i >= n) ? 1'b0 : bits[i];
      for (int h = 0; h < 2; h++)
      begin
        @(posedge clk);
        #1 line = b ^ (h == 1);
        repeat (t / 2 - 1) @(posedge clk);
      end
    end
    @(posedge clk);
    #1 line = 1'b1;
    repeat (2 * t) @(posedge clk);
    #1;
  endtask : send
endmodule : mpl_ctrl_model
`default_nettype wire

// [mpl_link.sv]
// Supply-line Manchester programming link: receiver, command decode, reply path.
// Assumes line_in is the synchronous comparator output of the supply (idle high),
// and that reg_rd_data holds the addressed register one cycle after reg_rd_stb.
`timescale 1ns/1ps
`default_nettype none
module mpl_link
  import mpl_pkg::*;
#(
  parameter int BIT_MIN = BIT_MIN_CYCLES,
  parameter int BIT_MAX = BIT_MAX_CYCLES,
  parameter int UNLOCK_CYCLES = UNLOCK_WINDOW_CYCLES,
  // Arbitrary value
  parameter logic [31:0] ACCESS_CODE = 32'h5A3C_96E1
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Supply line and configuration
  input wire logic line_in,
  input wire logic pwm_variant,
  input wire logic nonvolatile_write_lock,
  input wire logic pwm_level,
  // Output pin, open drain
  output logic sensor_output_pin_o,
  output logic sensor_output_pin_oe,
  output logic normal_output_en,
  // Register space
  output logic reg_wr_stb,
  output logic [5:0] reg_wr_addr,
  output logic [31:0] reg_wr_data,
  output logic reg_rd_stb,
  output logic [5:0] reg_rd_addr,
  input wire logic [31:0] reg_rd_data,
  // Status
  output logic unlocked,
  output logic manchester_mode,
  output logic link_owns_pin,
  output logic frame_error
);

  mpl_rx_state_t state_q;
  logic line_q;
  logic pwm_variant_q;
  logic [16:0] cnt_q;
  logic [16:0] bit_q;
  logic [5:0] nbits_q;
  logic [41:0] sr_q;
  logic frame_done_q;
  logic window_open_q;
  logic [23:0] window_cnt_q;
  logic reply_wait_q;
  logic [17:0] reply_cnt_q;
  logic tx_start_q;
  logic [34:0] tx_payload_q;
  logic tx_level;
  logic tx_busy;
  logic fall;
  logic rise;
  logic [16:0] three_q_bit;
  logic [16:0] five_q_bit;
  logic is_read;
  logic len_ok;
  logic [38:0] payload;
  logic crc_ok;
  logic accept;
  logic [5:0] f_addr;
  logic [31:0] f_data;
  logic reply_allowed;

  assign fall = line_q && !line_in;
  assign rise = !line_q && line_in;
  assign three_q_bit = (bit_q >> 1) + (bit_q >> 2);
  assign five_q_bit = bit_q + (bit_q >> 2);

  // ****************************************
  // Frame decode
  // ****************************************
  assign is_read = sr_q[nbits_q - 6'h01] == RW_READ;
  assign len_ok = is_read ? (nbits_q == READ_FRAME_BITS) : (nbits_q == WRITE_FRAME_BITS);
  assign payload = is_read ? {32'h0000_0000, sr_q[9:3]} : sr_q[41:3];
  assign crc_ok = mpl_crc3(payload, is_read ? READ_PAYLOAD_BITS : WRITE_PAYLOAD_BITS)
    == sr_q[2:0];
  assign f_addr = is_read ? sr_q[8:3] : sr_q[40:35];
  assign f_data = sr_q[34:3];
  assign accept = frame_done_q && len_ok && crc_ok && (unlocked || window_open_q);
  assign reply_allowed = manchester_mode && (!pwm_variant_q || link_owns_pin);

  // ****************************************
  // Line sampling and strap
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      line_q <= 1'b1;
      pwm_variant_q <= 1'b0;
    end
    else
    begin
      line_q <= line_in;
      pwm_variant_q <= pwm_variant;
    end
  end

  // ****************************************
  // Receiver: sync, bit period, data bits
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= MPL_RX_IDLE;
      cnt_q <= '0;
      bit_q <= '0;
      nbits_q <= '0;
      sr_q <= '0;
      frame_done_q <= 1'b0;
    end
    else
    begin
      frame_done_q <= 1'b0;
      if (cnt_q != 17'h1FFFF)
      begin
        cnt_q <= cnt_q + 17'h00001;
      end
      case (state_q)
        MPL_RX_IDLE:
        begin
          if (fall)
          begin
            cnt_q <= '0;
            state_q <= MPL_RX_RISE1;
          end
        end
        MPL_RX_RISE1:
        begin
          if (rise)
          begin
            state_q <= MPL_RX_FALL;
          end
          else if (cnt_q > 17'(BIT_MAX))
          begin
            state_q <= MPL_RX_IDLE;
          end
        end
        MPL_RX_FALL:
        begin
          if (fall)
          begin
            if (cnt_q >= 17'(BIT_MIN) && cnt_q <= 17'(BIT_MAX))
            begin
              bit_q <= cnt_q + 17'h00001;
              cnt_q <= '0;
              state_q <= MPL_RX_RISE2;
            end
            else
            begin
              state_q <= MPL_RX_IDLE;
            end
          end
          else if (cnt_q > 17'(BIT_MAX))
          begin
            state_q <= MPL_RX_IDLE;
          end
        end
        MPL_RX_RISE2:
        begin
          if (rise)
          begin
            cnt_q <= '0;
            nbits_q <= '0;
            state_q <= MPL_RX_DATA;
          end
          else if (fall || cnt_q > bit_q)
          begin
            state_q <= MPL_RX_IDLE;
          end
        end
        MPL_RX_DATA:
        begin
          if ((fall || rise) && cnt_q > three_q_bit)
          begin
            cnt_q <= '0;
            if (nbits_q == WRITE_FRAME_BITS)
            begin
              state_q <= MPL_RX_IDLE;
            end
            else
            begin
              sr_q <= {sr_q[40:0], fall};
              nbits_q <= nbits_q + 6'h01;
            end
          end
          else if (cnt_q > five_q_bit)
          begin
            frame_done_q <= nbits_q != 6'h00;
            state_q <= MPL_RX_IDLE;
          end
        end
        default:
        begin
          state_q <= MPL_RX_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Unlock window after power-up
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      window_cnt_q <= '0;
      window_open_q <= 1'b1;
    end
    else if (window_open_q)
    begin
      window_cnt_q <= window_cnt_q + 24'h000001;
      if (window_cnt_q + 24'h000001 >= 24'(UNLOCK_CYCLES))
      begin
        window_open_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Command execution
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      unlocked <= 1'b0;
      manchester_mode <= 1'b0;
      link_owns_pin <= 1'b0;
      frame_error <= 1'b0;
      reg_wr_stb <= 1'b0;
      reg_wr_addr <= '0;
      reg_wr_data <= '0;
      reg_rd_stb <= 1'b0;
      reg_rd_addr <= '0;
    end
    else
    begin
      reg_wr_stb <= 1'b0;
      reg_rd_stb <= 1'b0;
      frame_error <= frame_done_q && len_ok && !crc_ok;
      if (accept && !is_read)
      begin
        if (f_addr == ADDR_ACCESS_CMD)
        begin
          if (!unlocked)
          begin
            unlocked <= f_data == ACCESS_CODE;
          end
          else if (f_data == MAN_ENABLE_WORD)
          begin
            manchester_mode <= 1'b1;
          end
          else if (f_data == MAN_DISABLE_WORD)
          begin
            manchester_mode <= 1'b0;
            link_owns_pin <= 1'b0;
          end
        end
        else if (unlocked && f_addr == ADDR_DRIVER_HANDOVER)
        begin
          if (f_data == PWM_DISABLE_WORD && manchester_mode)
          begin
            link_owns_pin <= 1'b1;
          end
          else if (f_data == PWM_ENABLE_WORD)
          begin
            link_owns_pin <= 1'b0;
          end
        end
        else if (unlocked && !(nonvolatile_write_lock && f_addr <= NV_ADDR_LAST))
        begin
          reg_wr_stb <= 1'b1;
          reg_wr_addr <= f_addr;
          reg_wr_data <= f_data;
        end
      end
      if (accept && is_read && unlocked && reply_allowed && !reply_wait_q && !tx_busy)
      begin
        reg_rd_stb <= 1'b1;
        reg_rd_addr <= f_addr;
      end
    end
  end

  // ****************************************
  // Reply delay of two bit periods, then frame
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      reply_wait_q <= 1'b0;
      reply_cnt_q <= '0;
      tx_start_q <= 1'b0;
      tx_payload_q <= '0;
    end
    else
    begin
      tx_start_q <= 1'b0;
      if (reg_rd_stb)
      begin
        reply_wait_q <= 1'b1;
        reply_cnt_q <= '0;
      end
      else if (reply_wait_q)
      begin
        reply_cnt_q <= reply_cnt_q + 18'h00001;
        if (reply_cnt_q + 18'h00001 >= {bit_q, 1'b0})
        begin
          reply_wait_q <= 1'b0;
          tx_start_q <= reply_allowed;
          tx_payload_q <= {reg_rd_data,
            mpl_crc3({7'h00, reg_rd_data}, REPLY_PAYLOAD_BITS)};
        end
      end
    end
  end

  mpl_reply_tx u_reply_tx (
    .clk(clk),
    .rst(rst),
    .start(tx_start_q),
    .half_bit(bit_q >> 1),
    .payload(tx_payload_q),
    .level(tx_level),
    .busy(tx_busy)
  );

  // ****************************************
  // Output pin ownership
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sensor_output_pin_o <= 1'b0;
      sensor_output_pin_oe <= 1'b0;
      normal_output_en <= 1'b1;
    end
    else
    begin
      sensor_output_pin_o <= 1'b0;
      normal_output_en <= !manchester_mode;
      if (reply_allowed)
      begin
        sensor_output_pin_oe <= tx_busy && !tx_level;
      end
      else if (pwm_variant_q && !link_owns_pin)
      begin
        sensor_output_pin_oe <= !pwm_level;
      end
      else
      begin
        sensor_output_pin_oe <= 1'b0;
      end
    end
  end

endmodule : mpl_link
`default_nettype wire

// [mpl_link_checker.sv]
// Concurrent checks on the ports of the Manchester programming link.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module mpl_link_checker
  import mpl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Configuration
  input wire logic pwm_variant,
  input wire logic nonvolatile_write_lock,
  input wire logic pwm_level,
  // Pin and register side
  input wire logic sensor_output_pin_o,
  input wire logic sensor_output_pin_oe,
  input wire logic normal_output_en,
  input wire logic reg_wr_stb,
  input wire logic [5:0] reg_wr_addr,
  input wire logic reg_rd_stb,
  // Status
  input wire logic unlocked,
  input wire logic manchester_mode,
  input wire logic link_owns_pin,
  input wire logic frame_error
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_pin_drive_low: assert property (sensor_output_pin_o == 1'b0)
    else $error("pin data not low");
  chk_normal_en_mode: assert property (normal_output_en == !$past(manchester_mode))
    else $error("normal output enable wrong");
  chk_wr_one_cycle: assert property (reg_wr_stb |=> !reg_wr_stb)
    else $error("write strobe too long");
  chk_wr_unlocked: assert property (reg_wr_stb |-> unlocked
    && reg_wr_addr != ADDR_ACCESS_CMD && reg_wr_addr != ADDR_DRIVER_HANDOVER)
    else $error("write while locked or to command place");
  chk_nv_write_lock: assert property (reg_wr_stb && reg_wr_addr <= NV_ADDR_LAST
    |-> !$past(nonvolatile_write_lock))
    else $error("nonvolatile write while locked");
  chk_rd_allowed: assert property (reg_rd_stb
    |-> manchester_mode && (!pwm_variant || link_owns_pin))
    else $error("read outside manchester mode");
  chk_rd_gap: assert property (reg_rd_stb |=> !sensor_output_pin_oe [*8])
    else $error("reply too early");
  chk_owns_mode: assert property (link_owns_pin |-> manchester_mode)
    else $error("pin owned outside manchester mode");
  chk_mode_unlock: assert property (manchester_mode |-> unlocked)
    else $error("mode set while locked");
  chk_err_no_action: assert property (frame_error
    |-> !reg_wr_stb && !reg_rd_stb && $stable(manchester_mode))
    else $error("bad frame acted on");
  chk_pwm_follow: assert property (pwm_variant && $past(pwm_variant, 2) && !$past(rst)
    && !$past(rst, 2)
    && !link_owns_pin && !$past(link_owns_pin) |-> sensor_output_pin_oe == !$past(pwm_level))
    else $error("pin not following modulator");

  cov_read: cover property (reg_rd_stb);
  cov_error: cover property (frame_error);
  cov_exit: cover property ($fell(manchester_mode));
endmodule : mpl_link_checker
`default_nettype wire

// [mpl_pkg.sv]
// Constants, field layout and timing of the supply-line Manchester programming link.
// Assumes a 200 MHz system clock; all cycle counts derive from it.
package mpl_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 5;
  localparam int UNLOCK_WINDOW_MS = 70;
  localparam int UNLOCK_WINDOW_CYCLES = UNLOCK_WINDOW_MS * 1000000 / CLK_PERIOD_NS;
  localparam int BIT_RATE_MAX_KBPS = 40;
  localparam int BIT_RATE_MIN_KBPS = 5;
  localparam int BIT_TIME_ERR_PCT = 15;
  localparam int BIT_TIME_SHORT_NS = 1000000 / BIT_RATE_MAX_KBPS;
  localparam int BIT_TIME_LONG_NS = 1000000 / BIT_RATE_MIN_KBPS;
  localparam int BIT_MIN_CYCLES =
    (BIT_TIME_SHORT_NS * (100 - BIT_TIME_ERR_PCT) + 100 * CLK_PERIOD_NS - 1)
    / (100 * CLK_PERIOD_NS);
  localparam int BIT_MAX_CYCLES =
    BIT_TIME_LONG_NS * (100 + BIT_TIME_ERR_PCT) / (100 * CLK_PERIOD_NS);

  // ****************************************
  // Addresses and command words
  // ****************************************
  localparam logic [5:0] ADDR_ACCESS_CMD = 6'h1F;
  localparam logic [5:0] ADDR_DRIVER_HANDOVER = 6'h22;
  localparam logic [5:0] NV_ADDR_LAST = 6'h1E;
  localparam logic [31:0] MAN_ENABLE_WORD = 32'h5245_4144;
  localparam logic [31:0] MAN_DISABLE_WORD = 32'h4558_4954;
  localparam logic [31:0] PWM_DISABLE_WORD = 32'h001E_6C0D;
  localparam logic [31:0] PWM_ENABLE_WORD = 32'h021E_6C0D;

  // ****************************************
  // Frame layout
  // ****************************************
  localparam logic RW_WRITE = 1'b0;
  localparam logic RW_READ = 1'b1;
  localparam logic [5:0] READ_FRAME_BITS = 6'h0A;
  localparam logic [5:0] WRITE_FRAME_BITS = 6'h2A;
  localparam logic [5:0] READ_PAYLOAD_BITS = 6'h07;
  localparam logic [5:0] WRITE_PAYLOAD_BITS = 6'h27;
  localparam logic [5:0] REPLY_PAYLOAD_BITS = 6'h20;
  localparam logic [2:0] CRC_SEED = 3'h7;
  localparam logic [6:0] REPLY_HALF_CELLS = 7'h4A;

  typedef enum logic [2:0] {
    MPL_RX_IDLE = 3'b000,
    MPL_RX_RISE1 = 3'b001,
    MPL_RX_FALL = 3'b011,
    MPL_RX_RISE2 = 3'b010,
    MPL_RX_DATA = 3'b110
  } mpl_rx_state_t;

  // CRC x^3+x+1 over the low n bits of bits, MSB first
  function automatic logic [2:0] mpl_crc3(input logic [38:0] bits, input logic [5:0] n);
    logic [2:0] c;
    logic fb;
    c = CRC_SEED;
    fb = 1'b0;
    for (int i = 38; i >= 0; i--)
    begin
      if (i < int'(n))
      begin
        fb = c[2] ^ bits[i];
        c = {c[1], c[0] ^ fb, fb};
      end
    end
    return c;
  endfunction : mpl_crc3

endpackage : mpl_pkg

// [mpl_reply_tx.sv]
// Manchester serializer for read-acknowledge frames.
// Assumes start is a one-cycle pulse and half_bit stays stable during a frame.
`timescale 1ns/1ps
`default_nettype none
module mpl_reply_tx
  import mpl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Frame request
  input wire logic start,
  input wire logic [16:0] half_bit,
  input wire logic [34:0] payload,
  // Line
  output logic level,
  output logic busy
);

  logic [36:0] shift_q;
  logic [16:0] cnt_q;
  logic [6:0] halves_q;
  logic second_q;

  // ****************************************
  // Half-cell sequencer
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      shift_q <= '0;
      cnt_q <= '0;
      halves_q <= '0;
      second_q <= 1'b0;
      busy <= 1'b0;
      level <= 1'b1;
    end
    else if (start && !busy)
    begin
      shift_q <= {2'b00, payload};
      cnt_q <= '0;
      halves_q <= REPLY_HALF_CELLS;
      second_q <= 1'b0;
      busy <= 1'b1;
      level <= 1'b0;
    end
    else if (busy)
    begin
      if (cnt_q + 17'h00001 >= half_bit)
      begin
        cnt_q <= '0;
        halves_q <= halves_q - 7'h01;
        if (halves_q == 7'h01)
        begin
          busy <= 1'b0;
          level <= 1'b1;
        end
        else if (!second_q)
        begin
          second_q <= 1'b1;
          level <= ~shift_q[36];
        end
        else
        begin
          second_q <= 1'b0;
          shift_q <= {shift_q[35:0], 1'b0};
          level <= shift_q[35];
        end
      end
      else
      begin
        cnt_q <= cnt_q + 17'h00001;
      end
    end
  end

endmodule : mpl_reply_tx
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the Manchester programming link.
// Assumes mpl_ctrl_model drives the supply line.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import mpl_pkg::*;
  // Arbitrary value
  localparam logic [31:0] CODE = 32'h5A3C_96E1;
  logic clk, rst, line_in, pwm_variant, nonvolatile_write_lock, pwm_level;
  logic pin_o, pin_oe, norm_en, wr_stb, rd_stb, unl, man, own, ferr;
  logic [5:0] wr_addr, rd_addr, a;
  logic [31:0] wr_data, reg_rd_data;
  logic [31:0] mem [64];
  logic [38:0] exp_wr [$];
  int seed = 21;
  int n_mismatch = 0;
  int compares = 0;
  int t_cur = 40;
  int n_rd = 0;
  int n_err = 0;
  int cnt = 0;

  mpl_ctrl_model ctl (.clk(clk), .line(line_in));
  mpl_link #(.BIT_MIN(8), .BIT_MAX(200), .UNLOCK_CYCLES(20000), .ACCESS_CODE(CODE)) dut (
    .clk(clk), .rst(rst), .line_in(line_in), .pwm_variant(pwm_variant),
    .nonvolatile_write_lock(nonvolatile_write_lock), .pwm_level(pwm_level),
    .sensor_output_pin_o(pin_o), .sensor_output_pin_oe(pin_oe), .normal_output_en(norm_en),
    .reg_wr_stb(wr_stb), .reg_wr_addr(wr_addr), .reg_wr_data(wr_data), .reg_rd_stb(rd_stb),
    .reg_rd_addr(rd_addr), .reg_rd_data(reg_rd_data), .unlocked(unl), .manchester_mode(man),
    .link_owns_pin(own), .frame_error(ferr));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    compares++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  task automatic finish_test;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  function automatic logic [2:0] crc_of(input logic [38:0] v, input int n);
    logic [2:0] c;
    logic f;
    c = 3'h7;
    for (int i = n - 1; i >= 0; i--)
    begin
      f = c[2] ^ v[i];
      c = {c[1], c[0] ^ f, f};
    end
    return c;
  endfunction : crc_of

  task automatic wr(input logic [5:0] ad, input logic [31:0] d, input logic bad);
    logic [38:0] v;
    v = {RW_WRITE, ad, d};
    ctl.send({v, crc_of(v, 39) ^ {2'b00, bad}}, 42, t_cur);
  endtask : wr

  task automatic rd(input logic [5:0] ad);
    logic [38:0] v;
    v = {32'h0, RW_READ, ad};
    ctl.send({32'h0, v[6:0], crc_of(v, 7)}, 10, t_cur);
  endtask : rd

  task automatic st(input logic [3:0] e);
    chk("status", e, {unl, man, own, norm_en});
  endtask : st

  task automatic get_reply(input logic [34:0] e);
    logic [36:0] f, s;
    int k;
    k = 0;
    while (pin_oe !== 1'b1 && k < 8 * t_cur)
    begin
      cyc(1);
      k++;
    end
    chk("reply start", 1, pin_oe);
    cyc(t_cur / 4);
    for (int i = 36; i >= 0; i--)
    begin
      f[i] = !pin_oe;
      cyc(t_cur / 2);
      s[i] = pin_oe;
      cyc(t_cur / 2);
    end
    chk("reply first halves", {2'b00, e}, f);
    chk("reply second halves", {2'b00, e}, s);
  endtask : get_reply

  task automatic rd_none(input logic [5:0] ad);
    int c0;
    c0 = n_rd;
    rd(ad);
    cyc(6 * t_cur);
    chk("read strobes", c0, n_rd);
  endtask : rd_none

  // ****************************************
  // Register side model and monitors
  // ****************************************
  always @(posedge clk)
  begin
    cnt <= cnt + 1;
    pwm_level <= #1 cnt[3];
    if (rd_stb === 1'b1)
    begin
      n_rd <= n_rd + 1;
      reg_rd_data <= #1 mem[rd_addr];
    end
    if (ferr === 1'b1)
      n_err <= n_err + 1;
    if (wr_stb === 1'b1)
      chk("reg write", exp_wr.size() ? exp_wr.pop_front() : 39'h0, {1'b1, wr_addr, wr_data});
  end

  initial
  begin
    #450000;
    n_mismatch++;
    finish_test();
  end

  initial
  begin
    rst = 1'b1;
    pwm_variant = 1'b1;
    nonvolatile_write_lock = 1'b0;
    pwm_level = 1'b0;
    reg_rd_data = 32'h0;
    for (int i = 0; i < 64; i++)
      mem[i] = $random(seed);
    cyc(20);
    rst = 1'b0;
    st(4'h1);
    wr(6'h05, 32'h1234_5678, 1'b0);
    wr(ADDR_ACCESS_CMD, ~CODE, 1'b0);
    st(4'h1);
    wr(ADDR_ACCESS_CMD, CODE, 1'b1);
    st(4'h1);
    chk("frame errors", 1, n_err);
    wr(ADDR_ACCESS_CMD, CODE, 1'b0);
    st(4'h9);
    for (int i = 0; i < 5; i++)
    begin
      a = (i == 3) ? 6'h30 : 6'($unsigned($random(seed)) % 31);
      nonvolatile_write_lock = i[0];
      if (!i[0] || a > NV_ADDR_LAST)
      begin
        mem[a] = $random(seed);
        exp_wr.push_back({1'b1, a, mem[a]});
      end
      wr(a, (!i[0] || a > NV_ADDR_LAST) ? mem[a] : 32'hFFFF_0000, 1'b0);
    end
    nonvolatile_write_lock = 1'b0;
    rd_none(6'h05);
    wr(ADDR_ACCESS_CMD, MAN_ENABLE_WORD, 1'b0);
    st(4'hC);
    rd_none(6'h05);
    wr(ADDR_DRIVER_HANDOVER, PWM_DISABLE_WORD, 1'b0);
    st(4'hE);
    foreach (mem[i])
    begin
      if (i < 3)
      begin
        t_cur = (i == 0) ? 40 : (i == 1) ? 100 : 16;
        a = 6'($unsigned($random(seed)));
        rd(a);
        get_reply({mem[a], crc_of({7'h0, mem[a]}, 32)});
      end
    end
    t_cur = 40;
    chk("reads", 3, n_rd);
    wr(ADDR_DRIVER_HANDOVER, PWM_ENABLE_WORD, 1'b0);
    st(4'hC);
    wr(ADDR_ACCESS_CMD, MAN_DISABLE_WORD, 1'b0);
    st(4'h9);
    pwm_variant = 1'b0;
    wr(ADDR_ACCESS_CMD, MAN_ENABLE_WORD, 1'b0);
    a = 6'($unsigned($random(seed)));
    rd(a);
    get_reply({mem[a], crc_of({7'h0, mem[a]}, 32)});
    wr(ADDR_ACCESS_CMD, MAN_DISABLE_WORD, 1'b0);
    st(4'h9);
    chk("writes left", 0, exp_wr.size());
    rst = 1'b1;
    cyc(20);
    rst = 1'b0;
    cyc(20100);
    wr(ADDR_ACCESS_CMD, CODE, 1'b0);
    st(4'h1);
    finish_test();
  end
endmodule : tb_top

bind mpl_link mpl_link_checker u_chk (
  .clk(clk), .rst(rst), .pwm_variant(pwm_variant),
  .nonvolatile_write_lock(nonvolatile_write_lock), .pwm_level(pwm_level),
  .sensor_output_pin_o(sensor_output_pin_o), .sensor_output_pin_oe(sensor_output_pin_oe),
  .normal_output_en(normal_output_en), .reg_wr_stb(reg_wr_stb), .reg_wr_addr(reg_wr_addr),
  .reg_rd_stb(reg_rd_stb), .unlocked(unlocked), .manchester_mode(manchester_mode),
  .link_owns_pin(link_owns_pin), .frame_error(frame_error));
`default_nettype wire
